// ==== rtl/sbl_boot_loader.sv ====
// serial boot loader: serial port receiver, record parser, checksum, flags
// assumes SCL/SCK, SDA, CDIN, chip select and boot pins are asynchronous
`timescale 1ns/1ps
module sbl_boot_loader
	import sbl_pkg::*;
#(
	parameter int ADDR_W = SBL_ADDR_W
)
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// boot strap pins
	input wire logic BOOT_SEL,
	input wire logic CHIP_SEL_N,
	// serial control port
	input wire logic SCL_SCK,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic CDIN,
	output logic REQ_N_OUT,
	output logic REQ_N_OE,
	// memory write port
	output logic MEM_WR,
	output logic [ADDR_W-1:0] MEM_ADDR,
	output logic [7:0] MEM_DATA,
	input wire logic MEM_READY,
	// core control
	output logic [15:0] PROG_COUNTER,
	output logic SOFT_RESET,
	output logic BOOT_ACTIVE,
	// application flags
	input wire logic [3:0] APP_FLAG_SET,
	output logic [3:0] EXT_FLAG_OE
);
	// three-stage synchronisers; stage 1 only feeds stage 2
	logic [2:0] scl_s, sda_s, din_s, csn_s, boot_s;
	logic scl_q, sda_q, csn_q, boot_q, rst_q;
	always_ff @(posedge CORE_CLK)
	begin
		scl_s <= {scl_s[1:0], SCL_SCK};
		sda_s <= {sda_s[1:0], SDA_IN};
		din_s <= {din_s[1:0], CDIN};
		csn_s <= {csn_s[1:0], CHIP_SEL_N};
		boot_s <= {boot_s[1:0], BOOT_SEL};
	end
	// a level counts only once stages two and three agree
	always_ff @(posedge CORE_CLK)
	begin
		if (scl_s[1] == scl_s[2]) scl_q <= scl_s[2];
		if (sda_s[1] == sda_s[2]) sda_q <= sda_s[2];
		if (csn_s[1] == csn_s[2]) csn_q <= csn_s[2];
		if (boot_s[1] == boot_s[2]) boot_q <= boot_s[2];
		rst_q <= RST_N;
	end

	// edges, and reset release sampling straps after the clock
	logic scl_d, sda_d;
	wire scl_rise = scl_q & ~scl_d;
	wire scl_fall = ~scl_q & scl_d;
	wire rst_rise = RST_N & ~rst_q;
	always_ff @(posedge CORE_CLK)
	begin
		scl_d <= scl_q;
		sda_d <= sda_q;
	end

	// port framing chosen at boot entry from chip select
	logic i2c_mode;
	wire i2c_start = i2c_mode & scl_q & sda_d & ~sda_q;
	wire i2c_stop = i2c_mode & scl_q & ~sda_d & sda_q;
	wire spi_idle = ~i2c_mode & csn_q;
	wire data_bit = i2c_mode ? sda_q : din_s[2];

	// shift register; bit counts: address phase then data bytes
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic addr_phase, ack_phase, byte_evt;
	logic [7:0] rx_byte;
	wire last_bit = (bitcnt == SBL_BITS_PER_BYTE - 4'h1);
	always_ff @(posedge CORE_CLK)
	begin
		byte_evt <= 1'b0;
		if (!RST_N || i2c_start || spi_idle)
		begin
			bitcnt <= 4'h0;
			addr_phase <= 1'b1;
			ack_phase <= 1'b0;
		end
		else if (scl_rise && !ack_phase)
		begin
			shreg <= {shreg[6:0], data_bit};
		end
		else if (scl_fall)
		begin
			if (ack_phase)
				ack_phase <= 1'b0;
			else if (last_bit)
			begin
				bitcnt <= 4'h0;
				ack_phase <= i2c_mode;
				addr_phase <= 1'b0;
				// address is never compared during boot
				if (!addr_phase)
				begin
					rx_byte <= shreg;
					byte_evt <= 1'b1;
				end
			end
			else
				bitcnt <= bitcnt + 4'h1;
		end
	end
	// ack driven low in I2C ack slot, open drain
	assign SDA_OUT = 1'b0;

	// two-entry buffer between receiver and parser
	logic [7:0] fifo_mem [2];
	logic [1:0] fifo_cnt;
	logic fifo_wp, fifo_rp;
	wire fifo_in_ready = (fifo_cnt != 2'h2);
	wire fifo_out_valid = (fifo_cnt != 2'h0);
	wire [7:0] fifo_out = fifo_mem[fifo_rp];
	logic parse_ready;
	wire push = byte_evt & fifo_in_ready;
	wire pop = fifo_out_valid & parse_ready;
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			fifo_cnt <= 2'h0;
			fifo_wp <= 1'b0;
			fifo_rp <= 1'b0;
		end
		else
		begin
			if (push) fifo_mem[fifo_wp] <= rx_byte;
			fifo_wp <= fifo_wp ^ push;
			fifo_rp <= fifo_rp ^ pop;
			fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// record parser and checksum
	sbl_state_e state, next_state;
	logic [ADDR_W-1:0] addr;
	logic [15:0] len;
	logic [SBL_SUM_W-1:0] sum, tail_sum;
	logic req_fail, hi_ff;
	wire boot_active_w = (state != SBL_RUN) && (state != SBL_IDLE);
	assign SDA_OE = ack_phase & boot_active_w;
	wire is_ff = (fifo_out == SBL_TERM_BYTE);
	// data state stalls for memory, other loading states take any byte; check, fail, idle and run take none
	assign parse_ready = boot_active_w && state != SBL_CHECK && state != SBL_FAIL
		&& (state != SBL_DATA || MEM_READY);

	always_comb
	begin
		next_state = state;
		unique case (state)
			SBL_ADR_HI: if (pop) next_state = SBL_ADR_LO;
			// FF FF in address slot ends the image
			SBL_ADR_LO: if (pop) next_state = (hi_ff && is_ff) ? SBL_SUM0 : SBL_LEN_HI;
			SBL_LEN_HI: if (pop) next_state = SBL_LEN_LO;
			SBL_LEN_LO: if (pop) next_state = SBL_DATA;
			SBL_DATA: if (pop && len == 16'h0001) next_state = SBL_ADR_HI;
			SBL_SUM0: if (pop) next_state = SBL_SUM1;
			SBL_SUM1: if (pop) next_state = SBL_SUM2;
			SBL_SUM2: if (pop) next_state = SBL_CHECK;
			SBL_CHECK: next_state = (tail_sum == sum) ? SBL_RUN : SBL_FAIL;
			SBL_FAIL, SBL_RUN, SBL_IDLE: next_state = state;
			default: next_state = SBL_IDLE;
		endcase
	end

	// a zero-length record skips straight to the next address
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			state <= SBL_IDLE;
		else if (rst_rise && boot_q)
			state <= SBL_ADR_HI;
		else if (rst_rise)
			state <= SBL_RUN;
		else if (state == SBL_LEN_LO && pop && {len[7:0], fifo_out} == 16'h0000)
			state <= SBL_ADR_HI;
		else
			state <= next_state;
	end

	// datapath: address, length, running sum of all record bytes
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N || rst_rise)
		begin
			sum <= '0;
			tail_sum <= '0;
			hi_ff <= 1'b0;
			len <= 16'h0000;
			addr <= '0;
			i2c_mode <= csn_q;
		end
		else if (pop)
		begin
			// terminator and tail bytes stay out of the sum
			// the first FF was already added as an address byte, so take it back
			if (state == SBL_ADR_LO && hi_ff && is_ff)
				sum <= sum - {{(SBL_SUM_W-8){1'b0}}, SBL_TERM_BYTE};
			else if (state != SBL_SUM0 && state != SBL_SUM1 && state != SBL_SUM2)
				sum <= sum + {{(SBL_SUM_W-8){1'b0}}, fifo_out};
			unique case (state)
				SBL_ADR_HI: hi_ff <= is_ff;
				SBL_ADR_LO: addr <= ADDR_W'({addr[7:0], fifo_out});
				SBL_LEN_HI: len <= {8'h00, fifo_out};
				SBL_LEN_LO: len <= {len[7:0], fifo_out};
				SBL_DATA:
				begin
					len <= len - 16'h0001;
					addr <= addr + ADDR_W'(1);
				end
				default: tail_sum <= {tail_sum[15:0], fifo_out};
			endcase
			if (state == SBL_ADR_HI) addr <= ADDR_W'({8'h00, fifo_out});
		end
	end
	// memory write strobe and data from flops
	always_ff @(posedge CORE_CLK)
	begin
		MEM_WR <= RST_N && pop && state == SBL_DATA;
		MEM_ADDR <= addr;
		MEM_DATA <= fifo_out;
	end

	// program counter, software reset, failure request
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			PROG_COUNTER <= 16'h0000;
			SOFT_RESET <= 1'b0;
			req_fail <= 1'b0;
		end
		else
		begin
			SOFT_RESET <= 1'b0;
			if (rst_rise && boot_q)
			begin
				PROG_COUNTER <= SBL_ROM_START;
				req_fail <= 1'b0;
			end
			else if ((rst_rise && !boot_q) || (state == SBL_CHECK && tail_sum == sum))
			begin
				SOFT_RESET <= 1'b1;
				PROG_COUNTER <= SBL_APP_START;
			end
			else if (state == SBL_CHECK)
				req_fail <= 1'b1;
		end
	end
	// request only on checksum failure, never on lost framing
	assign REQ_N_OUT = 1'b0;
	assign REQ_N_OE = req_fail;
	assign BOOT_ACTIVE = boot_active_w;

	// open-drain flags, driven low when the application clears them
	logic [3:0] flags;
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N || SOFT_RESET)
			flags <= 4'h0;
		else
			flags <= APP_FLAG_SET;
	end
	assign EXT_FLAG_OE = ~flags;

	a_fail_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state == SBL_FAIL) |-> REQ_N_OE) else $error("fail without request");
	a_fail_no_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state == SBL_CHECK && tail_sum != sum) |=> !SOFT_RESET) else $error("reset on bad sum");
	a_good_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state == SBL_CHECK && tail_sum == sum) |=> SOFT_RESET && PROG_COUNTER == SBL_APP_START)
		else $error("no reset on good sum");
	a_boot_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(rst_rise && boot_q) |=> state == SBL_ADR_HI && PROG_COUNTER == SBL_ROM_START)
		else $error("boot not entered");
	a_noboot_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(rst_rise && !boot_q) |=> SOFT_RESET && state == SBL_RUN) else $error("no soft reset");
	a_req_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(REQ_N_OE && !(rst_rise && boot_q)) |=> REQ_N_OE) else $error("request dropped");
	a_mem_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(pop && state == SBL_DATA) |=> MEM_WR && MEM_DATA == $past(fifo_out))
		else $error("data byte not written");
	a_flags_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		##1 !$past(SOFT_RESET) |-> EXT_FLAG_OE == ~$past(APP_FLAG_SET))
		else $error("flag mismatch");
	a_fifo_bound: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		fifo_cnt <= 2'h2) else $error("buffer overrun");
endmodule

// ==== rtl/sbl_pkg.sv ====
// package for the serial boot loader: image format, state codes, sizes
// assumes one core clock domain; serial port pins sampled by the loader
// Contract
// - boot starts on reset rise with boot high
// - boot entry sets program counter to ROM start
// - received bytes written to program/data memory
// - good checksum raises software reset, runs application
// - reset with boot low acts as software reset
// - chip select picks I2C high, SPI low
// - boot I2C ignores slave address match
// - checksum is 24-bit sum of prior bytes
// - compare running sum with tail checksum
// - mismatch drives request low, no software reset
// - lost framing never drops request
// - four open-drain flags owned by application
// - byte latched on eighth bit falling edge
package sbl_pkg;
	localparam int SBL_ADDR_W = 16;
	localparam int SBL_SUM_W = 24;
	localparam logic [15:0] SBL_ROM_START = 16'h1000;
	localparam logic [15:0] SBL_APP_START = 16'h0000;
	localparam logic [7:0] SBL_TERM_BYTE = 8'hFF;
	localparam logic [3:0] SBL_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SBL_ADDR_BITS_I2C = 4'h8;
	typedef enum logic [3:0]
	{
		SBL_IDLE = 4'h0,
		SBL_ADR_HI = 4'h1,
		SBL_ADR_LO = 4'h3,
		SBL_LEN_HI = 4'h2,
		SBL_LEN_LO = 4'h6,
		SBL_DATA = 4'h7,
		SBL_SUM0 = 4'h5,
		SBL_SUM1 = 4'h4,
		SBL_SUM2 = 4'hC,
		SBL_CHECK = 4'hD,
		SBL_FAIL = 4'hF,
		SBL_RUN = 4'hE
	} sbl_state_e;
endpackage

// ==== tb/sbl_host_model.sv ====
// host model: streams a download image over the control port in SPI framing
// assumes the loader samples the serial clock with its own core clock
`timescale 1ns/1ps
module sbl_host_model
(
	// serial control port
	output logic sck,
	output logic cdin,
	output logic cs_n,
	// level of the pulled-up throttle flag wire
	input wire logic throttle
);
	logic [23:0] sum;

	// chip select low at boot start picks SPI framing
	initial
	begin
		sck = 1'b0;
		cdin = 1'b0;
		cs_n = 1'b0;
		sum = 24'h0;
	end

	task automatic select_spi();
		cs_n = 1'b0;
		sum = 24'h0;
	endtask

	// one frame: discarded address byte, then data msb first, 160 ns bit period
	task automatic send_byte(input logic [7:0] b);
		logic [15:0] sh;
		sh = {8'h00, b};
		// deselected while held off, so the wait is visible on chip select
		while (throttle === 1'b1)
		begin
			cs_n = 1'b1;
			#160;
		end
		cs_n = 1'b0;
		#80;
		for (int i = 15; i >= 0; i--)
		begin
			cdin = sh[i];
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
		#80 cs_n = 1'b1;
		cdin = ~cdin; // released line keeps no value
		#160;
	endtask

	// record byte: counted into the 24-bit running sum
	task automatic send_rec(input logic [7:0] b);
		sum = sum + {16'h0, b};
		send_byte(b);
	endtask

	// terminator pair then sum msb first; bad flips only the sum bytes
	task automatic send_tail(input logic bad);
		logic [23:0] s;
		s = bad ? ~sum : sum;
		send_byte(8'hFF);
		send_byte(8'hFF);
		send_byte(s[23:16]);
		send_byte(s[15:8]);
		send_byte(s[7:0]);
	endtask
endmodule

// ==== tb/tb_sbl_boot_loader.sv ====
// testbench for the serial boot loader: boot entry, load, bad sum, flags
// assumes the SPI host model drives the serial pins asynchronously
`timescale 1ns/1ps
module tb_sbl_boot_loader;
	import sbl_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic boot_sel = 1'b1;
	logic mem_ready = 1'b1;
	logic [3:0] app_flag_set = 4'h0;
	logic sda_in = 1'b1; // idle I2C data line, pulled up
	logic sck, cdin, cs_n, sda_out, sda_oe, req_n_out, req_n_oe, mem_wr, soft_reset, boot_active;
	logic [15:0] mem_addr;
	logic [7:0] mem_data;
	logic [15:0] pc;
	logic [3:0] ext_flag_oe;
	logic [23:0] wr_q[$];
	int soft_cnt = 0;
	int err_count = 0;
	int checked = 0;
	int s;
	wire throttle_flag_out = ext_flag_oe[0] ? 1'b0 : 1'b1; // pull-up on open drain

	always #2.5 core_clk = ~core_clk;

	sbl_boot_loader i_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .BOOT_SEL(boot_sel),
		.CHIP_SEL_N(cs_n), .SCL_SCK(sck), .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.CDIN(cdin), .REQ_N_OUT(req_n_out), .REQ_N_OE(req_n_oe), .MEM_WR(mem_wr),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MEM_READY(mem_ready), .PROG_COUNTER(pc),
		.SOFT_RESET(soft_reset), .BOOT_ACTIVE(boot_active), .APP_FLAG_SET(app_flag_set),
		.EXT_FLAG_OE(ext_flag_oe));

	sbl_host_model i_host (.sck(sck), .cdin(cdin), .cs_n(cs_n), .throttle(throttle_flag_out));

	// memory writes and soft reset pulses, sampled every rising edge
	always @(posedge core_clk)
	begin
		if (mem_wr === 1'b1)
			wr_q.push_back({mem_addr, mem_data});
		if (soft_reset === 1'b1)
			soft_cnt++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// eight edges low so the strap synchronisers settle before release
	task automatic do_reset(input logic boot);
		@(posedge core_clk) #1;
		rst_n = 1'b0;
		boot_sel = boot;
		i_host.select_spi();
		repeat (8) @(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
	endtask

	task automatic t_boot_entry();
		do_reset(1'b1);
		check(pc, SBL_ROM_START);
		check(boot_active, 1'b1);
	endtask

	// stall the memory across both data bytes; the buffer must keep them
	task automatic t_good_image();
		do_reset(1'b1);
		wr_q.delete();
		s = soft_cnt;
		i_host.send_rec(8'h00);
		i_host.send_rec(8'h10);
		i_host.send_rec(8'h00);
		i_host.send_rec(8'h02);
		mem_ready = 1'b0;
		i_host.send_rec(8'hAB);
		i_host.send_rec(8'hCD);
		check(wr_q.size(), 0);
		#1 mem_ready = 1'b1;
		repeat (20) @(posedge core_clk);
		check(wr_q.size(), 2);
		check(wr_q[0], 24'h0010AB);
		check(wr_q[1], 24'h0011CD);
		i_host.send_tail(1'b0);
		repeat (200) @(posedge core_clk);
		check(soft_cnt - s, 1);
		check(pc, SBL_APP_START);
		check(req_n_oe, 1'b0);
		check(boot_active, 1'b0);
	endtask

	// only the sum bytes are corrupted; request must fall and stay down
	task automatic t_bad_sum();
		do_reset(1'b1);
		s = soft_cnt;
		i_host.send_rec(8'h00);
		i_host.send_rec(8'h20);
		i_host.send_rec(8'h00);
		i_host.send_rec(8'h01);
		i_host.send_rec(8'h5A);
		i_host.send_tail(1'b1);
		repeat (200) @(posedge core_clk);
		check(req_n_oe, 1'b1);
		check(soft_cnt - s, 0);
		repeat (500) @(posedge core_clk);
		check(req_n_oe, 1'b1);
		do_reset(1'b1);
		check(req_n_oe, 1'b0);
	endtask

	// reset with the strap low: soft reset, no loader
	task automatic t_soft_reset();
		s = soft_cnt;
		do_reset(1'b0);
		check(soft_cnt - s, 1);
		check(pc, SBL_APP_START);
		check(boot_active, 1'b0);
	endtask

	// flags follow the application; host holds off while the throttle is high
	task automatic t_flags();
		app_flag_set = 4'h5;
		repeat (4) @(posedge core_clk);
		check(ext_flag_oe, 4'hA);
		fork
			i_host.send_byte(8'h00);
		join_none
		repeat (100) @(posedge core_clk);
		check(cs_n, 1'b1);
		#1 app_flag_set = 4'h0;
		wait fork;
		check(ext_flag_oe, 4'hF);
	endtask

	initial
	begin
		t_boot_entry();
		t_good_image();
		t_bad_sum();
		t_soft_reset();
		t_flags();
		print_verdict();
	end

	// watchdog well past the expected run of about 14000 cycles
	initial
	begin
		repeat (60000) @(posedge core_clk);
		err_count++;
		print_verdict();
	end
endmodule
